// file: tb/nmta_rx_model.sv
`timescale 1ns/1ps
module nmta_rx_model (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Sync reset, high
  input wire logic bit_i, // Serial message bit
  input wire logic valid_i, // Bit valid pulse
  input wire logic start_i, // First bit pulse
  output logic [8:0] pos_o, // Position of last bit taken
  output int n_fields_o, // Count of field strobes
  output logic [7:0] pre_o, // Preamble
  output logic [5:0] sat_o, // Satellite number
  output logic [5:0] typ_o, // Message type
  output logic [12:0] week_o, // Week number
  output logic [2:0] health_o, // Signal health
  output logic [10:0] top_o, // Predict time of week
  output logic signed [4:0] acc_o, // Accuracy index
  output logic isf_o, // Integrity level flag
  output logic phase_o, // Phase relationship flag
  output logic no_pred_o, // No accuracy prediction
  output logic [11:0] scale_o, // Integrity scale times 100
  output logic signed [5:0] nom2_o, // Twice log2 of nominal accuracy
  output logic [15:0] nom_dm_o, // Nominal accuracy in decimetres
  output logic [15:0] adj_dm_o // Nominal accuracy at 60 degrees elevation
);
  logic [1:300] msg_q;
  logic [8:0] nxt;
  logic signed [5:0] n6;
  // ----------------------------------------
  // Bit capture by position, first bit is 1
  // ----------------------------------------
  assign nxt = start_i ? 9'h001 : pos_o + 9'h001;
  always @(posedge clk_i) begin
    if (rst_i) begin
      pos_o <= 9'h000;
      n_fields_o <= 0;
    end else if (valid_i) begin
      msg_q[nxt] <= bit_i;
      pos_o <= nxt;
      if (nxt == 9'h111 && typ_o == 6'h0a && pre_o == 8'h8b) begin
        n_fields_o <= n_fields_o + 1;
      end
    end
  end
  // ----------------------------------------
  // Field extraction, most significant first
  // ----------------------------------------
  assign pre_o = msg_q[1:8];
  assign sat_o = msg_q[9:14];
  assign typ_o = msg_q[15:20];
  assign week_o = msg_q[39:51];
  assign health_o = msg_q[52:54];
  assign top_o = msg_q[55:65];
  assign acc_o = msg_q[66:70];
  assign isf_o = msg_q[272];
  assign phase_o = msg_q[273];
  assign no_pred_o = (acc_o == 5'sh0f);
  assign scale_o = isf_o ? 12'h23d : 12'h1ba;
  assign n6 = acc_o;
  assign nom2_o = (acc_o <= 5'sh06) ? n6 + 6'sh02 : (n6 <<< 1) - 6'sh04;
  // Nominal accuracy for indices 0 to 14, zero otherwise
  always_comb begin
    nom_dm_o = 16'h0000;
    if (acc_o == 5'sh01) begin
      nom_dm_o = 16'h001c;
    end else if (acc_o == 5'sh03) begin
      nom_dm_o = 16'h0039;
    end else if (acc_o == 5'sh05) begin
      nom_dm_o = 16'h0071;
    end else if (acc_o >= 5'sh00 && acc_o <= 5'sh06) begin
      nom_dm_o = 16'h000a << (acc_o / 2 + 1);
    end else if (acc_o > 5'sh06 && acc_o < 5'sh0f) begin
      nom_dm_o = 16'h000a << (acc_o - 5'sh02);
    end
  end
  // Sine of 60 plus 90 degrees is one half
  assign adj_dm_o = nom_dm_o >> 1;
endmodule

// file: tb/test_nav_msg_type10_accuracy_decoder.sv
`timescale 1ns/1ps
module test_nav_msg_type10_accuracy_decoder;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic tick = 1'b0;
  logic [31:0] rdata;
  logic nav_bit, nav_valid, msg_start, irq;
  logic [8:0] pos;
  int n_fields;
  logic [7:0] pre;
  logic [5:0] sat, typ;
  logic [12:0] week;
  logic [2:0] health;
  logic [10:0] top;
  logic signed [4:0] acc;
  logic integrity_level_flag, phase, no_pred;
  logic [11:0] scale;
  logic signed [5:0] nom2;
  logic [15:0] nom_dm, adj_dm;
  logic [31:0] v;
  int failures = 0;
  int n_checks = 0;
  int i;

  always #5 clk = ~clk;
  always @(posedge clk) tick <= srst ? 1'b0 : ~tick;

  nmta_framer u_dut (.CORE_CLK_I(clk), .SRST_I(srst), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
    .REG_WR_I(wr), .REG_RD_I(rd), .BIT_ENABLE_I(tick), .REG_RDATA_O(rdata), .NAV_BIT_O(nav_bit),
    .NAV_BIT_VALID_O(nav_valid), .MSG_START_O(msg_start), .IRQ_O(irq));
  nmta_rx_model u_rx (.clk_i(clk), .rst_i(srst), .bit_i(nav_bit), .valid_i(nav_valid),
    .start_i(msg_start), .pos_o(pos), .n_fields_o(n_fields), .pre_o(pre), .sat_o(sat), .typ_o(typ),
    .week_o(week), .health_o(health), .top_o(top), .acc_o(acc), .isf_o(integrity_level_flag), .phase_o(phase),
    .no_pred_o(no_pred), .scale_o(scale), .nom2_o(nom2), .nom_dm_o(nom_dm), .adj_dm_o(adj_dm));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task results();
    if (failures == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task wait_fields(input int k);
    for (i = 0; i < 2000 && n_fields < k; i++) begin
      @(posedge clk);
      #1;
    end
    if (n_fields < k) begin
      failures++;
      results();
    end
  endtask

  task setup_msg(input logic [12:0] wk, input logic [10:0] tp, input logic [14:0] fl);
    reg_wr(nmta_pkg::REG_WEEK, {19'h0, wk});
    reg_wr(nmta_pkg::REG_TOP, {21'h0, tp});
    reg_wr(nmta_pkg::REG_FLAGS, {17'h0, fl});
    reg_wr(nmta_pkg::REG_LOAD, 32'h1);
  endtask

  task check_msg(input logic [12:0] wk, input logic [10:0] tp, input logic [14:0] fl);
    check(pre, 8'h8b);
    check(typ, 6'h0a);
    check(sat, 6'h01);
    check(week, wk);
    check(health, fl[2:0]);
    check(top, tp);
    check(acc, $signed(fl[8:4]));
    check(integrity_level_flag, fl[12]);
    check(phase, fl[13]);
    check(scale, fl[12] ? 12'h23d : 12'h1ba);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    reg_rd(nmta_pkg::REG_FLAGS, v);
    check(v, 32'h0000_00f7);
    reg_rd(4'h7, v);
    check(v, 32'h0);
    // Negative boundary index, enhanced integrity, alert set
    setup_msg(13'h1a5c, 11'h5a3, 15'h5105);
    reg_rd(nmta_pkg::REG_LOAD, v);
    check(v, 32'h1);
    reg_wr(nmta_pkg::REG_CTRL, 32'h1);
    wait_fields(1);
    check_msg(13'h1a5c, 11'h5a3, 15'h5105);
    check(acc, 5'sh10);
    check(nom2, 6'sh32);
    // Next message queued mid-frame, second load request refused as error
    setup_msg(13'h0001, 11'h000, 15'h20f2);
    reg_wr(nmta_pkg::REG_LOAD, 32'h1);
    wait_fields(2);
    check_msg(13'h0001, 11'h000, 15'h20f2);
    check(no_pred, 1'b1);
    check(nom_dm, 16'h0000);
    // Default message follows, then stop
    for (i = 0; i < 400 && pos != 9'h001; i++) begin
      @(posedge clk);
      #1;
    end
    check(pos, 9'h001);
    reg_wr(nmta_pkg::REG_CTRL, 32'h0);
    v = 32'h200;
    for (i = 0; i < 400 && v[9]; i++) begin
      reg_rd(nmta_pkg::REG_CTRL, v);
    end
    check(v[9], 1'b0);
    check(typ, 6'h00);
    check(week, 13'h1555);
    check(n_fields, 2);
    // Interrupt: sticky status, mask, write one to clear
    reg_rd(nmta_pkg::REG_STATUS, v);
    check(v, 32'h3);
    check(irq, 1'b0);
    reg_wr(nmta_pkg::REG_MASK, 32'h1);
    repeat (2) @(posedge clk);
    #1 check(irq, 1'b1);
    reg_wr(nmta_pkg::REG_STATUS, 32'h1);
    repeat (2) @(posedge clk);
    #1 check(irq, 1'b0);
    reg_wr(nmta_pkg::REG_MASK, 32'h3);
    repeat (2) @(posedge clk);
    #1 check(irq, 1'b1);
    reg_wr(nmta_pkg::REG_STATUS, 32'h2);
    reg_rd(nmta_pkg::REG_STATUS, v);
    check(v, 32'h0);
    #1 check(irq, 1'b0);
    // Rounded nominal accuracy and elevation scaling on index 5
    setup_msg(13'h1fff, 11'h7ff, 15'h1053);
    reg_wr(nmta_pkg::REG_CTRL, 32'h1);
    wait_fields(3);
    check_msg(13'h1fff, 11'h7ff, 15'h1053);
    check(nom2, 6'sh07);
    check(nom_dm, 16'h0071);
    check(adj_dm, 16'h0038);
    check(no_pred, 1'b0);
    reg_wr(nmta_pkg::REG_CTRL, 32'h0);
    results();
  end
endmodule

// file: verilog/nmta_framer.sv
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module nmta_framer #(
  parameter logic [5:0] SAT_NUMBER = 6'h01 // Arbitrary satellite number
) (
  input wire logic CORE_CLK_I, // Clock 100 MHz
  input wire logic SRST_I, // Sync reset, high
  input wire logic [3:0] REG_ADDR_I, // Register index
  input wire logic [31:0] REG_WDATA_I, // Write data
  input wire logic REG_WR_I, // Write strobe
  input wire logic REG_RD_I, // Read strobe
  input wire logic BIT_ENABLE_I, // One-cycle bit tick
  output logic [31:0] REG_RDATA_O, // Read data
  output logic NAV_BIT_O, // Serial message bit
  output logic NAV_BIT_VALID_O, // Bit valid pulse
  output logic MSG_START_O, // First bit pulse
  output logic IRQ_O // Level interrupt
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic enable_q;
  logic [nmta_pkg::WEEK_W-1:0] week_q;
  logic [nmta_pkg::TOP_W-1:0] top_q;
  logic [2:0] health_q;
  logic signed [nmta_pkg::ACC_W-1:0] acc_idx_q;
  logic integrity_level_flag_q;
  logic phase_flag_q;
  logic alert_q;
  logic [nmta_pkg::EVT_W-1:0] status_q;
  logic [nmta_pkg::EVT_W-1:0] mask_q;
  logic load_pend_q;
  logic [8:0] pos_q;
  logic busy_q;
  // Snapshot taken at message start
  logic [nmta_pkg::WEEK_W-1:0] s_week_q;
  logic [nmta_pkg::TOP_W-1:0] s_top_q;
  logic [2:0] s_health_q;
  logic [nmta_pkg::ACC_W-1:0] s_acc_q;
  logic s_isf_q;
  logic s_phase_q;
  logic s_alert_q;
  logic s_type10_q;
  logic evt_sent;
  logic evt_err;
  logic cur_bit;

  function automatic logic field_bit(input logic [15:0] val, input logic [8:0] pos,
                                     input logic [8:0] first, input int width);
    logic [8:0] off;
    off = pos - first;
    field_bit = val[width - 1 - int'(off)];
  endfunction

  function automatic logic in_field(input logic [8:0] pos, input logic [8:0] first, input int width);
    in_field = (pos >= first) && (pos < first + 9'(width));
  endfunction

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      enable_q <= 1'b0;
      week_q <= '0;
      top_q <= '0;
      health_q <= nmta_pkg::HEALTH_RST;
      acc_idx_q <= nmta_pkg::ACC_NONE;
      integrity_level_flag_q <= 1'b0;
      phase_flag_q <= 1'b0;
      alert_q <= 1'b0;
      mask_q <= '0;
    end else if (REG_WR_I) begin
      if (REG_ADDR_I == nmta_pkg::REG_CTRL) begin
        enable_q <= REG_WDATA_I[0];
      end else if (REG_ADDR_I == nmta_pkg::REG_WEEK) begin
        week_q <= REG_WDATA_I[nmta_pkg::WEEK_W-1:0];
      end else if (REG_ADDR_I == nmta_pkg::REG_TOP) begin
        top_q <= REG_WDATA_I[nmta_pkg::TOP_W-1:0];
      end else if (REG_ADDR_I == nmta_pkg::REG_FLAGS) begin
        health_q <= REG_WDATA_I[2:0];
        acc_idx_q <= REG_WDATA_I[8:4];
        integrity_level_flag_q <= REG_WDATA_I[12];
        phase_flag_q <= REG_WDATA_I[13];
        alert_q <= REG_WDATA_I[14];
      end else if (REG_ADDR_I == nmta_pkg::REG_MASK) begin
        mask_q <= REG_WDATA_I[nmta_pkg::EVT_W-1:0];
      end
    end
  end

  // Load request: next message carries the type-10 layout
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      load_pend_q <= 1'b0;
    end else if (REG_WR_I && REG_ADDR_I == nmta_pkg::REG_LOAD && REG_WDATA_I[0]) begin
      load_pend_q <= 1'b1;
    end else if (BIT_ENABLE_I && enable_q && (!busy_q || pos_q == nmta_pkg::POS_LAST)) begin
      load_pend_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Bit sequencer
  // ----------------------------------------
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      pos_q <= 9'h000;
      busy_q <= 1'b0;
      s_week_q <= '0;
      s_top_q <= '0;
      s_health_q <= '0;
      s_acc_q <= '0;
      s_isf_q <= 1'b0;
      s_phase_q <= 1'b0;
      s_alert_q <= 1'b0;
      s_type10_q <= 1'b0;
    end else if (BIT_ENABLE_I) begin
      if (!busy_q) begin
        if (enable_q) begin
          busy_q <= 1'b1;
          pos_q <= 9'h001;
          s_week_q <= week_q;
          s_top_q <= top_q;
          s_health_q <= health_q;
          s_acc_q <= acc_idx_q;
          s_isf_q <= integrity_level_flag_q;
          s_phase_q <= phase_flag_q;
          s_alert_q <= alert_q;
          s_type10_q <= load_pend_q;
        end
      end else if (pos_q == nmta_pkg::POS_LAST) begin
        busy_q <= enable_q;
        pos_q <= enable_q ? 9'h001 : 9'h000;
        s_week_q <= week_q;
        s_top_q <= top_q;
        s_health_q <= health_q;
        s_acc_q <= acc_idx_q;
        s_isf_q <= integrity_level_flag_q;
        s_phase_q <= phase_flag_q;
        s_alert_q <= alert_q;
        s_type10_q <= load_pend_q;
      end else begin
        pos_q <= pos_q + 9'h001;
      end
    end
  end

  // Bit mux; default message fills with alternating ones and zeros
  always_comb begin
    cur_bit = 1'b0;
    if (pos_q != 9'h000 && pos_q <= nmta_pkg::POS_PRE_LAST) begin
      cur_bit = nmta_pkg::PREAMBLE[3'(nmta_pkg::POS_PRE_LAST - pos_q)];
    end else if (in_field(pos_q, nmta_pkg::POS_SAT_FIRST, nmta_pkg::SAT_W)) begin
      cur_bit = field_bit(16'(SAT_NUMBER), pos_q, nmta_pkg::POS_SAT_FIRST, nmta_pkg::SAT_W);
    end else if (in_field(pos_q, nmta_pkg::POS_TYPE_FIRST, nmta_pkg::TYPE_W)) begin
      cur_bit = field_bit(s_type10_q ? 16'(nmta_pkg::TYPE_EPH1) : 16'(nmta_pkg::DEFAULT_TYPE),
                          pos_q, nmta_pkg::POS_TYPE_FIRST, nmta_pkg::TYPE_W);
    end else if (pos_q == nmta_pkg::POS_ALERT) begin
      cur_bit = s_alert_q;
    end else if (pos_q < nmta_pkg::POS_WEEK_FIRST) begin
      cur_bit = 1'b0;
    end else if (!s_type10_q) begin
      cur_bit = (pos_q <= nmta_pkg::POS_FILL_LAST) ? pos_q[0] : 1'b0;
    end else if (in_field(pos_q, nmta_pkg::POS_WEEK_FIRST, nmta_pkg::WEEK_W)) begin
      cur_bit = field_bit(16'(s_week_q), pos_q, nmta_pkg::POS_WEEK_FIRST, nmta_pkg::WEEK_W);
    end else if (in_field(pos_q, nmta_pkg::POS_HEALTH_L1, nmta_pkg::HEALTH_W)) begin
      cur_bit = field_bit(16'(s_health_q), pos_q, nmta_pkg::POS_HEALTH_L1, nmta_pkg::HEALTH_W);
    end else if (in_field(pos_q, nmta_pkg::POS_TOP_FIRST, nmta_pkg::TOP_W)) begin
      cur_bit = field_bit(16'(s_top_q), pos_q, nmta_pkg::POS_TOP_FIRST, nmta_pkg::TOP_W);
    end else if (in_field(pos_q, nmta_pkg::POS_ACC_FIRST, nmta_pkg::ACC_W)) begin
      cur_bit = field_bit(16'(s_acc_q), pos_q, nmta_pkg::POS_ACC_FIRST, nmta_pkg::ACC_W);
    end else if (pos_q == nmta_pkg::POS_ISF) begin
      cur_bit = s_isf_q;
    end else if (pos_q == nmta_pkg::POS_PHASE) begin
      cur_bit = s_phase_q;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      NAV_BIT_O <= 1'b0;
      NAV_BIT_VALID_O <= 1'b0;
      MSG_START_O <= 1'b0;
    end else begin
      NAV_BIT_VALID_O <= BIT_ENABLE_I && busy_q;
      MSG_START_O <= BIT_ENABLE_I && busy_q && pos_q == 9'h001;
      if (BIT_ENABLE_I && busy_q) begin
        NAV_BIT_O <= cur_bit;
      end
    end
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  assign evt_sent = BIT_ENABLE_I && busy_q && pos_q == nmta_pkg::POS_LAST;
  assign evt_err = REG_WR_I && REG_ADDR_I == nmta_pkg::REG_LOAD && load_pend_q;

  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      status_q <= '0;
    end else begin
      status_q <= (status_q & ~((REG_WR_I && REG_ADDR_I == nmta_pkg::REG_STATUS) ?
                   REG_WDATA_I[nmta_pkg::EVT_W-1:0] : '0))
                  | {evt_err, evt_sent};
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= |(status_q & mask_q);
    end
  end

  // ----------------------------------------
  // Register reads
  // ----------------------------------------
  always_ff @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      REG_RDATA_O <= '0;
    end else if (REG_RD_I) begin
      if (REG_ADDR_I == nmta_pkg::REG_CTRL) begin
        REG_RDATA_O <= {22'h0, busy_q, pos_q};
      end else if (REG_ADDR_I == nmta_pkg::REG_WEEK) begin
        REG_RDATA_O <= 32'(week_q);
      end else if (REG_ADDR_I == nmta_pkg::REG_TOP) begin
        REG_RDATA_O <= 32'(top_q);
      end else if (REG_ADDR_I == nmta_pkg::REG_FLAGS) begin
        REG_RDATA_O <= {17'h0, alert_q, phase_flag_q, integrity_level_flag_q, 3'h0, acc_idx_q, 1'b0, health_q};
      end else if (REG_ADDR_I == nmta_pkg::REG_STATUS) begin
        REG_RDATA_O <= 32'(status_q);
      end else if (REG_ADDR_I == nmta_pkg::REG_MASK) begin
        REG_RDATA_O <= 32'(mask_q);
      end else if (REG_ADDR_I == nmta_pkg::REG_LOAD) begin
        REG_RDATA_O <= 32'(load_pend_q);
      end else begin
        REG_RDATA_O <= '0;
      end
    end else begin
      REG_RDATA_O <= '0;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_preamble_first: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    MSG_START_O |-> NAV_BIT_O == 1'b1) else $error("Preamble first bit not one");
  a_isf_bit: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    BIT_ENABLE_I && busy_q && s_type10_q && pos_q == nmta_pkg::POS_ISF |=> NAV_BIT_O == s_isf_q)
    else $error("Integrity flag bit wrong");
  a_phase_bit: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    BIT_ENABLE_I && busy_q && s_type10_q && pos_q == nmta_pkg::POS_PHASE |=> NAV_BIT_O == s_phase_q)
    else $error("Phase flag bit wrong");
  a_week_msb: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    BIT_ENABLE_I && busy_q && s_type10_q && pos_q == nmta_pkg::POS_WEEK_FIRST |=> NAV_BIT_O == s_week_q[12])
    else $error("Week msb wrong");
  a_health_l5: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    BIT_ENABLE_I && busy_q && s_type10_q && pos_q == nmta_pkg::POS_HEALTH_L5 |=> NAV_BIT_O == s_health_q[0])
    else $error("Health bit wrong");
  a_top_lsb: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    BIT_ENABLE_I && busy_q && s_type10_q && pos_q == nmta_pkg::POS_TOP_LAST |=> NAV_BIT_O == s_top_q[0])
    else $error("Predict time lsb wrong");
  a_acc_sign: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    BIT_ENABLE_I && busy_q && s_type10_q && pos_q == nmta_pkg::POS_ACC_FIRST |=> NAV_BIT_O == s_acc_q[4])
    else $error("Accuracy sign bit wrong");
  a_pos_range: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    busy_q |-> pos_q >= 9'd1 && pos_q <= nmta_pkg::POS_LAST) else $error("Bit position out of range");

  sequence s_tick_at(logic [8:0] p);
    BIT_ENABLE_I && busy_q && pos_q == p;
  endsequence
  a_load_taken: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    s_tick_at(nmta_pkg::POS_LAST) ##0 (enable_q && !REG_WR_I) |=> !load_pend_q)
    else $error("Load request not taken at message start");
  a_type_mark: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    s_tick_at(nmta_pkg::POS_TYPE_LAST - 9'd1) |=> NAV_BIT_O == s_type10_q)
    else $error("Message type bit wrong");
  a_fill_bit: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
    s_tick_at(nmta_pkg::POS_WEEK_FIRST) ##0 !s_type10_q |=> NAV_BIT_O == 1'b1)
    else $error("Default fill bit wrong");
endmodule

// file: verilog/nmta_pkg.sv
package nmta_pkg;
  // ----------------------------------------
  // Message framing
  // ----------------------------------------
  localparam int MSG_BITS = 300;
  localparam logic [7:0] PREAMBLE = 8'h8b;
  localparam logic [5:0] TYPE_EPH1 = 6'h0a;
  localparam logic [5:0] DEFAULT_TYPE = 6'h00;
  localparam logic [8:0] POS_PRE_LAST = 9'd8;
  localparam logic [8:0] POS_TYPE_FIRST = 9'd15;
  localparam logic [8:0] POS_TYPE_LAST = 9'd20;
  localparam logic [8:0] POS_ALERT = 9'd38;
  localparam logic [8:0] POS_WEEK_FIRST = 9'd39;
  localparam logic [8:0] POS_HEALTH_L1 = 9'd52;
  localparam logic [8:0] POS_TOP_FIRST = 9'd55;
  localparam logic [8:0] POS_ACC_FIRST = 9'd66;
  localparam logic [8:0] POS_ACC_LAST = 9'd70;
  localparam logic [8:0] POS_ISF = 9'd272;
  localparam logic [8:0] POS_PHASE = 9'd273;
  localparam logic [8:0] POS_LAST = 9'd300;
  localparam logic [8:0] POS_SAT_FIRST = 9'd9;
  localparam logic [8:0] POS_FILL_LAST = 9'd276;
  localparam logic [8:0] POS_HEALTH_L5 = 9'd54;
  localparam logic [8:0] POS_TOP_LAST = 9'd65;
  localparam int SAT_W = 6;
  localparam int TYPE_W = 6;
  localparam int HEALTH_W = 3;
  localparam logic [2:0] HEALTH_RST = 3'h7;
  localparam int WEEK_W = 13;
  localparam int TOP_W = 11;
  localparam int ACC_W = 5;
  // ----------------------------------------
  // Accuracy index encoding
  // ----------------------------------------
  localparam logic signed [4:0] ACC_NONE = 5'sh0f;
  localparam logic signed [4:0] ACC_MIN = 5'sh10;
  localparam logic [11:0] ISF_SCALE_LEGACY = 12'h1ba;
  localparam logic [11:0] ISF_SCALE_ENH = 12'h23d;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_WEEK = 4'h1;
  localparam logic [3:0] REG_TOP = 4'h2;
  localparam logic [3:0] REG_FLAGS = 4'h3;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_MASK = 4'h5;
  localparam logic [3:0] REG_LOAD = 4'h6;
  localparam int EVT_SENT = 0;
  localparam int EVT_ERR = 1;
  localparam int EVT_W = 2;
endpackage
